/* File: rtl/psu_oe_regs.svh */
`ifndef PSU_OE_REGS_SVH
`define PSU_OE_REGS_SVH

// ----------------------------------------------------------------------
// clock rate
// ----------------------------------------------------------------------
`define SYS_CLK_KHZ 100000

// ----------------------------------------------------------------------
// timing figures in milliseconds, and the derived cycle counts
// ----------------------------------------------------------------------
`define DEBOUNCE_MS 2
`define DEBOUNCE_CYC (`DEBOUNCE_MS * `SYS_CLK_KHZ)
`define TURN_ON_DELAY_MIN_MS 5
`define TURN_ON_DELAY_MAX_MS 400
`define TURN_ON_DELAY_CYC (`TURN_ON_DELAY_MIN_MS * `SYS_CLK_KHZ)
`define OFF_TO_GOOD_DROP_DELAY_MAX_MS 5
`define GOOD_ON_DELAY_MIN_MS 100
`define GOOD_ON_DELAY_MAX_MS 500
`define GOOD_ON_DELAY_CYC (`GOOD_ON_DELAY_MIN_MS * `SYS_CLK_KHZ)
`define GOOD_OFF_LEAD_MS 1
`define GOOD_OFF_LEAD_CYC (`GOOD_OFF_LEAD_MS * `SYS_CLK_KHZ)

// ----------------------------------------------------------------------
// slot addresses
// ----------------------------------------------------------------------
`define MGMT_ADDR_BASE 8'hb0
`define FRU_ADDR_BASE 8'ha0
`define SLOT_BIT0_POS 1
`define SLOT_BIT1_POS 2

// ----------------------------------------------------------------------
// synchronised pin vector: positions and reset levels
// ----------------------------------------------------------------------
`define PIN_ON_REQ 0
`define PIN_CUTOFF 1
`define PIN_SLOT0 2
`define PIN_SLOT1 3
`define PIN_IN_REG 4
`define PIN_UV 5
`define PIN_MAINS_LOST 6
`define PIN_AC_LOSS 7
`define PIN_FAN_FAIL 8
`define PIN_OVER_TEMP 9
`define PIN_OVP 10
`define PIN_SYNC_RESET 11'h003
`define EARLY_SEL_RESET 3'h7

`endif

/* File: rtl/psu_oe_pkg.sv */
package psu_oe_pkg;

	// ------------------------------------------------------------------
	// shared types
	// ------------------------------------------------------------------
	// wide enough for the longest wait (500 ms at 100 MHz)
	typedef logic [26:0] timer_t;

	// synchronised pin vector
	typedef logic [10:0] pins_t;

	// output sequencing states, one-hot
	typedef enum logic [5:0] {
		ST_OFF     = 6'b000001,
		ST_ON_WAIT = 6'b000010,
		ST_RAMP    = 6'b000100,
		ST_SETTLE  = 6'b001000,
		ST_GOOD    = 6'b010000,
		ST_DROP    = 6'b100000
	} seq_state_e;

endpackage : psu_oe_pkg

/* File: rtl/level_debounce.sv */
`include "psu_oe_regs.svh"

// ----------------------------------------------------------------------
// level debouncer: the output follows the input only after the input
// has held one level for STABLE_CYC consecutive cycles
// ----------------------------------------------------------------------
module level_debounce #(
	parameter int unsigned STABLE_CYC = `DEBOUNCE_CYC,
	parameter bit RESET_LEVEL = 1'b1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// levels
	input wire logic level_in,
	output logic level_out
);

	psu_oe_pkg::timer_t count_reg; // cycles the input has differed
	psu_oe_pkg::timer_t count_next;
	logic level_reg; // accepted level
	logic level_next;

	// count while the input disagrees; any agreement restarts the count,
	// so a bouncing contact never gets through
	always_comb begin
		count_next = '0;
		level_next = level_reg;
		if (level_in != level_reg) begin
			if (count_reg >= psu_oe_pkg::timer_t'(STABLE_CYC - 1)) begin
				level_next = level_in;
			end else begin
				count_next = count_reg + 27'h1;
			end
		end
	end

	// registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= '0;
			level_reg <= RESET_LEVEL;
		end else begin
			count_reg <= count_next;
			level_reg <= level_next;
		end
	end

	assign level_out = level_reg;

endmodule : level_debounce

/* File: rtl/psu_output_enable_control.sv */
// Notes on behaviour
// [R1] low on-request enables the main rail
// [R2] request high or open: all but standby off
// [R3] undriven on-request reads as stay off
// [R4] on-request is debounced against switch bounce
// [R5] turn-on starts 5 ms to 400 ms after request
// [R6] request removed: output good drops within 5 ms
// [R7] good rises 100-500 ms after outputs settle
// [R8] good low on undervoltage or lost mains
// [R9] good falls at least 1 ms before rail off; on latched overvoltage good and rail drop together
// [R10] selectable early-drop sources: mains, fan, temperature
// [R11] system reads low inserted line as present
// [R12] cutoff high or open forces main off
// [R13] turn-on needs cutoff and request both low
// [R14] system grounds the cutoff mating contact
// [R15] identification memory serves byte, sequential, write, page
// [R16] management address 0xb0-0xb6 from slot pins
// [R17] identification address 0xa0-0xa6 from slot pins
// [R18] identification content uses standard unit data format
// [R19] overvoltage latch clears by request off then on
// [R20] good drops before output on enable removal
`include "psu_oe_regs.svh"

module psu_output_enable_control #(
	parameter int unsigned DEBOUNCE_CYC = `DEBOUNCE_CYC,
	parameter int unsigned TURN_ON_DELAY_CYC = `TURN_ON_DELAY_CYC,
	parameter int unsigned GOOD_ON_DELAY_CYC = `GOOD_ON_DELAY_CYC,
	parameter int unsigned GOOD_OFF_LEAD_CYC = `GOOD_OFF_LEAD_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// host-facing pins
	input wire logic on_request_n,
	input wire logic extract_cutoff_n,
	input wire logic slot_addr_bit0,
	input wire logic slot_addr_bit1,
	// analog supervisor levels
	input wire logic outputs_in_reg,
	input wire logic output_uv,
	input wire logic mains_lost,
	input wire logic ac_loss_warn,
	input wire logic fan_fail,
	input wire logic over_temp,
	input wire logic ovp_trip,
	// configuration from local logic: {over_temp, fan_fail, ac_loss}
	input wire logic [2:0] early_drop_sel,
	// outputs to power stage and pins
	output logic main_rail_en,
	output logic output_good,
	output logic module_inserted_n,
	output logic ovp_latched,
	output logic [7:0] mgmt_addr,
	output logic [7:0] fru_addr
);

	// ------------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------------

	// true on the last cycle of a wait of lim cycles
	function automatic logic timer_done(input psu_oe_pkg::timer_t t,
		input int unsigned lim);
		timer_done = (t >= psu_oe_pkg::timer_t'(lim - 1));
	endfunction : timer_done

	// place the two slot pins in address bits 2 and 1
	function automatic logic [7:0] slot_address(input logic [7:0] base,
		input logic bit1, input logic bit0);
		logic [7:0] a;
		a = base;
		a[`SLOT_BIT0_POS] = bit0;
		a[`SLOT_BIT1_POS] = bit1;
		slot_address = a;
	endfunction : slot_address

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	psu_oe_pkg::pins_t pins_raw; // raw pin levels
	psu_oe_pkg::pins_t sync1_reg; // first stage, read only by sync2
	psu_oe_pkg::pins_t sync2_reg; // second stage, safe to use

	assign pins_raw = {ovp_trip, over_temp, fan_fail, ac_loss_warn, mains_lost,
		output_uv, outputs_in_reg, slot_addr_bit1, slot_addr_bit0,
		extract_cutoff_n, on_request_n};

	// request and cutoff reset high, as if their pull-ups were in charge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= `PIN_SYNC_RESET; // R3
			sync2_reg <= `PIN_SYNC_RESET;
		end else begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
		end
	end

	// ------------------------------------------------------------------
	// request debounce
	// ------------------------------------------------------------------
	logic req_n_clean; // debounced on-request, active low

	// the cutoff is not debounced: extraction has to act quickly
	level_debounce #(
		.STABLE_CYC(DEBOUNCE_CYC),
		.RESET_LEVEL(1'b1)
	) u_req_debounce (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.level_in(sync2_reg[`PIN_ON_REQ]),
		.level_out(req_n_clean)
	); // R4

	// ------------------------------------------------------------------
	// combined conditions
	// ------------------------------------------------------------------
	logic req_on; // request asserted
	logic cutoff_ok; // cutoff pin held low
	logic enable; // both permit turn-on
	logic early_drop; // selected warning source active
	logic out_fault; // undervoltage or lost mains
	logic in_reg; // every output within regulation

	always_comb begin
		req_on = !req_n_clean; // R1
		cutoff_ok = !sync2_reg[`PIN_CUTOFF]; // R12
		enable = req_on && cutoff_ok; // R13
		early_drop = |(early_drop_sel & {sync2_reg[`PIN_OVER_TEMP],
			sync2_reg[`PIN_FAN_FAIL], sync2_reg[`PIN_AC_LOSS]}); // R10
		out_fault = sync2_reg[`PIN_UV] || sync2_reg[`PIN_MAINS_LOST]; // R8
		in_reg = sync2_reg[`PIN_IN_REG];
	end

	// ------------------------------------------------------------------
	// overvoltage latch
	// ------------------------------------------------------------------
	logic ovp_reg; // latched overvoltage shutdown
	logic ovp_next;
	logic ovp_seen_off_reg; // request went off while latched
	logic ovp_seen_off_next;

	// the trip wins over a clear in the same cycle; clearing needs the
	// request to go off and then come back on
	always_comb begin
		ovp_next = ovp_reg;
		ovp_seen_off_next = ovp_seen_off_reg;
		if (sync2_reg[`PIN_OVP]) begin
			ovp_next = 1'b1;
			ovp_seen_off_next = 1'b0;
		end else if (ovp_reg) begin
			if (!req_on) begin
				ovp_seen_off_next = 1'b1;
			end else if (ovp_seen_off_reg) begin
				ovp_next = 1'b0; // R19
				ovp_seen_off_next = 1'b0;
			end
		end
	end

	// registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ovp_reg <= 1'b0;
			ovp_seen_off_reg <= 1'b0;
		end else begin
			ovp_reg <= ovp_next;
			ovp_seen_off_reg <= ovp_seen_off_next;
		end
	end

	// ------------------------------------------------------------------
	// output sequencer
	// ------------------------------------------------------------------
	psu_oe_pkg::seq_state_e state_reg; // sequencer state
	psu_oe_pkg::seq_state_e state_next;
	psu_oe_pkg::timer_t timer_reg; // cycles spent in the state
	psu_oe_pkg::timer_t timer_next;
	logic rail_en_reg; // main rail enable
	logic rail_en_next;
	logic good_reg; // output good
	logic good_next;

	// good is high only in ST_GOOD; leaving it passes ST_DROP unless overvoltage is latched,
	// which keeps the rail on for the warning lead before cutting it
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			psu_oe_pkg::ST_OFF: begin
				// all but standby are off here
				if (enable && !ovp_reg && !early_drop) begin
					state_next = psu_oe_pkg::ST_ON_WAIT;
				end
			end
			psu_oe_pkg::ST_ON_WAIT: begin
				// debounce plus this wait stays within 5 ms to 400 ms
				if (!enable || ovp_reg) begin
					state_next = psu_oe_pkg::ST_OFF; // R2
				end else if (timer_done(timer_reg, TURN_ON_DELAY_CYC)) begin
					state_next = psu_oe_pkg::ST_RAMP; // R5
				end
			end
			psu_oe_pkg::ST_RAMP: begin
				// good is still low, so the rail may go at once
				if (!enable || ovp_reg) begin
					state_next = psu_oe_pkg::ST_OFF; // R12
				end else if (in_reg && !out_fault) begin
					state_next = psu_oe_pkg::ST_SETTLE;
				end
			end
			psu_oe_pkg::ST_SETTLE: begin
				if (!enable || ovp_reg) begin
					state_next = psu_oe_pkg::ST_OFF;
				end else if (!in_reg || out_fault) begin
					state_next = psu_oe_pkg::ST_RAMP; // restart settle time
				end else if (timer_done(timer_reg, GOOD_ON_DELAY_CYC)) begin
					state_next = psu_oe_pkg::ST_GOOD; // R7
				end
			end
			psu_oe_pkg::ST_GOOD: begin
				// overvoltage is protection: no lead, rail off at once
				if (ovp_reg) begin
					state_next = psu_oe_pkg::ST_OFF;
				end else if (!enable) begin
					state_next = psu_oe_pkg::ST_DROP; // R20
				end else if (early_drop || out_fault || !in_reg) begin
					state_next = psu_oe_pkg::ST_DROP; // R8
				end
			end
			psu_oe_pkg::ST_DROP: begin
				if (ovp_reg || timer_done(timer_reg, GOOD_OFF_LEAD_CYC)) begin
					state_next = psu_oe_pkg::ST_OFF; // R9
				end
			end
			default: begin
				state_next = psu_oe_pkg::ST_OFF;
			end
		endcase

		// the timer restarts on every change of state
		if (state_next != state_reg) begin
			timer_next = '0;
		end else if (timer_reg == '1) begin
			timer_next = timer_reg;
		end else begin
			timer_next = timer_reg + 27'h1;
		end

		// outputs follow the next state so they leave flip-flops directly
		rail_en_next = (state_next == psu_oe_pkg::ST_RAMP) ||
			(state_next == psu_oe_pkg::ST_SETTLE) ||
			(state_next == psu_oe_pkg::ST_GOOD) ||
			(state_next == psu_oe_pkg::ST_DROP); // R1
		good_next = (state_next == psu_oe_pkg::ST_GOOD); // R6
	end

	// registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= psu_oe_pkg::ST_OFF;
			timer_reg <= '0;
			rail_en_reg <= 1'b0;
			good_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			rail_en_reg <= rail_en_next;
			good_reg <= good_next;
		end
	end

	// ------------------------------------------------------------------
	// slot addresses and presence strap
	// ------------------------------------------------------------------
	logic [7:0] mgmt_addr_reg; // management bus address
	logic [7:0] mgmt_addr_next;
	logic [7:0] fru_addr_reg; // identification memory address
	logic [7:0] fru_addr_next;
	logic inserted_n_reg; // presence strap, tied low while powered
	logic inserted_n_next;

	// the memory itself (transfers and content) lives in a separate part;
	// this block only hands it its slot address
	always_comb begin
		mgmt_addr_next = slot_address(`MGMT_ADDR_BASE, sync2_reg[`PIN_SLOT1],
			sync2_reg[`PIN_SLOT0]); // R16
		fru_addr_next = slot_address(`FRU_ADDR_BASE, sync2_reg[`PIN_SLOT1],
			sync2_reg[`PIN_SLOT0]); // R15 R17 R18
		inserted_n_next = 1'b0;
	end

	// registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mgmt_addr_reg <= `MGMT_ADDR_BASE;
			fru_addr_reg <= `FRU_ADDR_BASE;
			inserted_n_reg <= 1'b0;
		end else begin
			mgmt_addr_reg <= mgmt_addr_next;
			fru_addr_reg <= fru_addr_next;
			inserted_n_reg <= inserted_n_next;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign main_rail_en = rail_en_reg;
	assign output_good = good_reg;
	assign module_inserted_n = inserted_n_reg;
	assign ovp_latched = ovp_reg;
	assign mgmt_addr = mgmt_addr_reg;
	assign fru_addr = fru_addr_reg;

endmodule : psu_output_enable_control

/* File: verification/psu_oe_props.sv */
// ----------------------------------------------------------------------
// port checker for the output enable controller
// ----------------------------------------------------------------------
module psu_oe_props #(
	parameter int unsigned DEBOUNCE_CYC = 20,
	parameter int unsigned GOOD_ON_DELAY_CYC = 50,
	parameter int unsigned GOOD_OFF_LEAD_CYC = 10
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// pins and levels
	input wire logic on_request_n,
	input wire logic extract_cutoff_n,
	input wire logic slot_addr_bit0,
	input wire logic slot_addr_bit1,
	input wire logic outputs_in_reg,
	input wire logic output_uv,
	// outputs
	input wire logic main_rail_en,
	input wire logic output_good,
	input wire logic module_inserted_n,
	input wire logic ovp_latched,
	input wire logic [7:0] mgmt_addr,
	input wire logic [7:0] fru_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	// lead plus sync slack before the rail must be off
	localparam int RAIL_LIM = int'(GOOD_OFF_LEAD_CYC) + 8;
	// cycles the request pin has stayed high, saturating
	int unsigned req_hi;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			req_hi <= 0;
		else if (!on_request_n)
			req_hi <= 0;
		else if (req_hi < 1000)
			req_hi <= req_hi + 1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_rail_on_cause:
	assert property ($rose(main_rail_en) |-> !on_request_n && !extract_cutoff_n)
		else $error("rail on without request and permit");
	a_cutoff_good_low:
	assert property (extract_cutoff_n [*6] |-> !output_good)
		else $error("good high with cutoff open");
	a_cutoff_rail_off:
	assert property ($rose(extract_cutoff_n) |-> ##[1:RAIL_LIM] !main_rail_en)
		else $error("rail still on after cutoff");
	a_req_off_good:
	assert property (req_hi >= DEBOUNCE_CYC + 6 |-> !output_good)
		else $error("good high after request release");
	a_good_rise_cause:
	assert property ($rose(output_good) |->
		main_rail_en && $past(outputs_in_reg, GOOD_ON_DELAY_CYC))
		else $error("good rose too early");
	a_good_lead_time:
	assert property ($fell(main_rail_en) && !ovp_latched |->
		$past(!output_good, GOOD_OFF_LEAD_CYC))
		else $error("good did not lead rail off");
	a_uv_good_low:
	assert property (output_uv [*6] |-> !output_good)
		else $error("good high under undervoltage");
	a_slot_addr_map:
	assert property ($stable({slot_addr_bit1, slot_addr_bit0}) [*5] |->
		mgmt_addr == (8'hb0 | {5'h00, slot_addr_bit1, slot_addr_bit0, 1'b0}) &&
		fru_addr == (8'ha0 | {5'h00, slot_addr_bit1, slot_addr_bit0, 1'b0}))
		else $error("slot address map wrong");
	a_ovp_rail_off:
	assert property (ovp_latched |=> !main_rail_en && !output_good)
		else $error("rail on while overvoltage latched");
	a_ovp_clear_req:
	assert property ($fell(ovp_latched) |-> !on_request_n)
		else $error("latch cleared without request");
	a_inserted_low:
	assert property (module_inserted_n == 1'b0)
		else $error("inserted strap not low");
endmodule : psu_oe_props

bind psu_output_enable_control psu_oe_props #(
	.DEBOUNCE_CYC(DEBOUNCE_CYC),
	.GOOD_ON_DELAY_CYC(GOOD_ON_DELAY_CYC),
	.GOOD_OFF_LEAD_CYC(GOOD_OFF_LEAD_CYC)
) u_props (.sys_clk(sys_clk), .rst_n(rst_n), .on_request_n(on_request_n),
	.extract_cutoff_n(extract_cutoff_n), .slot_addr_bit0(slot_addr_bit0),
	.slot_addr_bit1(slot_addr_bit1), .outputs_in_reg(outputs_in_reg),
	.output_uv(output_uv), .main_rail_en(main_rail_en), .output_good(output_good),
	.module_inserted_n(module_inserted_n), .ovp_latched(ovp_latched),
	.mgmt_addr(mgmt_addr), .fru_addr(fru_addr));

/* File: verification/board_seq.sv */
// ----------------------------------------------------------------------
// system board side: drives request, cutoff and slot pins
// ----------------------------------------------------------------------
module board_seq (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// commands from the bench
	input wire logic want_on,
	input wire logic seated,
	input wire logic bounce,
	input wire logic [1:0] slot,
	// pins toward the supply
	input wire logic module_inserted_n,
	output logic on_request_n,
	output logic extract_cutoff_n,
	output logic slot_addr_bit0,
	output logic slot_addr_bit1,
	output logic present
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] bnc_reg; // bounce phase, 4 cycles per level
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bnc_reg <= 3'h0;
			on_request_n <= 1'b1;
			extract_cutoff_n <= 1'b1;
			slot_addr_bit0 <= 1'b0;
			slot_addr_bit1 <= 1'b0;
			present <= 1'b0;
		end else begin
			bnc_reg <= bnc_reg + 3'h1;
			// released request floats high via the pull-up
			on_request_n <= bounce ? bnc_reg[2] : !want_on;
			// mating contact grounded only while seated
			extract_cutoff_n <= !seated;
			slot_addr_bit0 <= slot[0];
			slot_addr_bit1 <= slot[1];
			// low strap means a supply is in the slot
			present <= !module_inserted_n;
		end
	end
endmodule : board_seq

/* File: verification/psu_output_enable_control_bench.sv */
module psu_output_enable_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------------
	// shortened counts and stimulus
	// ------------------------------------------------------------------
	localparam int DB = 20;
	localparam int TON = 30;
	localparam int GON = 50;
	localparam int LEAD = 10;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic want_on = 1'b0;
	logic seated = 1'b0;
	logic bounce = 1'b0;
	logic [1:0] slot = 2'h0;
	logic in_reg = 1'b0;
	logic [4:0] flt = 5'h00; // uv, mains, ac, fan, temp
	logic ovp = 1'b0;
	logic [2:0] sel = 3'h7;
	logic on_n, cut_n, s0, s1, rail, good, ins_n, ovpl, present;
	logic [7:0] mgmt, fru;
	int fail_count = 0;
	int compares = 0;
	int n;
	board_seq u_board (.sys_clk(sys_clk), .rst_n(rst_n), .want_on(want_on),
		.seated(seated), .bounce(bounce), .slot(slot), .module_inserted_n(ins_n),
		.on_request_n(on_n), .extract_cutoff_n(cut_n), .slot_addr_bit0(s0),
		.slot_addr_bit1(s1), .present(present));
	psu_output_enable_control #(.DEBOUNCE_CYC(DB), .TURN_ON_DELAY_CYC(TON),
		.GOOD_ON_DELAY_CYC(GON), .GOOD_OFF_LEAD_CYC(LEAD)) dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .on_request_n(on_n),
		.extract_cutoff_n(cut_n), .slot_addr_bit0(s0), .slot_addr_bit1(s1),
		.outputs_in_reg(in_reg), .output_uv(flt[0]), .mains_lost(flt[1]),
		.ac_loss_warn(flt[2]), .fan_fail(flt[3]), .over_temp(flt[4]),
		.ovp_trip(ovp), .early_drop_sel(sel), .main_rail_en(rail),
		.output_good(good), .module_inserted_n(ins_n), .ovp_latched(ovpl),
		.mgmt_addr(mgmt), .fru_addr(fru));
	initial forever #5 sys_clk = ~sys_clk;
	// ------------------------------------------------------------------
	// tasks; reads follow an edge so they see settled pre-edge values
	// ------------------------------------------------------------------
	// automatic: the main sequence and the hang guard both wait through it
	task automatic tick(input int c);
		repeat (c) @(posedge sys_clk);
	endtask : tick
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// bounded wait on rail (pick 1) or good (pick 0)
	task wait_for(input bit pick, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while ((pick ? rail : good) !== lvl && cnt < lim) begin
			@(posedge sys_clk);
			cnt++;
		end
	endtask : wait_for
	// full off then on cycle, timing both delays
	task power_up;
		want_on <= 1'b0;
		in_reg <= 1'b0;
		wait_for(1'b1, 1'b0, 200, n);
		tick(DB + 10);
		want_on <= 1'b1;
		wait_for(1'b1, 1'b1, 200, n);
		check("on_delay", n >= DB + TON && n <= DB + TON + 10, 1'b1);
		in_reg <= 1'b1;
		wait_for(1'b0, 1'b1, 200, n);
		check("good_delay", n >= GON && n <= GON + 10, 1'b1);
	endtask : power_up
	// good must fall first, rail only after the lead time
	task check_drop(input string what, input int lim);
		wait_for(1'b0, 1'b0, lim, n);
		check(what, n < lim, 1'b1);
		check("rail_lead", rail, 1'b1);
		wait_for(1'b1, 1'b0, LEAD + 8, n);
		check("lead_time", n >= LEAD - 2 && n < LEAD + 8, 1'b1);
	endtask : check_drop
	task end_sim;
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	// ------------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------------
	initial begin
		tick(8);
		rst_n <= 1'b1;
		check("inserted", ins_n, 1'b0);
		check("mgmt_rst", mgmt, 8'hb0);
		check("fru_rst", fru, 8'ha0);
		for (int i = 0; i < 4; i++) begin
			slot <= i[1:0];
			tick(6);
			check("mgmt_addr", mgmt, 8'hb0 | (i[7:0] << 1));
			check("fru_addr", fru, 8'ha0 | (i[7:0] << 1));
		end
		check("present", present, 1'b1);
		want_on <= 1'b1;
		tick(200);
		check("rail_no_permit", rail, 1'b0);
		want_on <= 1'b0;
		seated <= 1'b1;
		tick(200);
		check("rail_no_request", rail, 1'b0);
		bounce <= 1'b1;
		tick(200);
		check("rail_bounce", rail, 1'b0);
		bounce <= 1'b0;
		power_up;
		want_on <= 1'b0;
		check_drop("good_req_off", DB + 10);
		power_up;
		seated <= 1'b0;
		check_drop("good_cutoff", 8);
		seated <= 1'b1;
		// every drop source in turn, all selected
		for (int i = 0; i < 5; i++) begin
			power_up;
			flt[i] <= 1'b1;
			check_drop("good_fault", 10);
			flt[i] <= 1'b0;
		end
		// an unselected warning leaves good alone
		power_up;
		sel <= 3'h3;
		flt[4] <= 1'b1;
		tick(30);
		check("good_masked", good, 1'b1);
		flt[4] <= 1'b0;
		sel <= 3'h7;
		ovp <= 1'b1;
		tick(1);
		ovp <= 1'b0;
		tick(8);
		check("ovp_latch", ovpl, 1'b1);
		check("ovp_rail", rail, 1'b0);
		power_up;
		check("ovp_clear", ovpl, 1'b0);
		end_sim;
	end
	// hang guard, well past the few thousand cycles the tests need
	initial begin
		tick(30000);
		fail_count++;
		end_sim;
	end
endmodule : psu_output_enable_control_bench
